// File: include/eth_port_pkg.sv
package eth_port_pkg;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] POLICE_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] DROPS_OFS = 8'h0C;
    // Control register fields and reset value.
    localparam int FC_BIT = 0;
    localparam int ROLE_BIT = 1;
    localparam int QOS_BIT = 2;
    localparam int LRN_BIT = 3;
    localparam int LOCK_BIT = 4;
    localparam int MODE_LSB = 5;
    localparam logic [6:0] PROT_MASK = 7'h66;
    localparam logic [6:0] CTRL_RST = 7'h10;
    // Policer register fields and reset values.
    localparam int CIR_LSB = 0;
    localparam int CBS_LSB = 16;
    localparam int EBS_LSB = 20;
    localparam logic [9:0] CIR_FULL = 10'h3E8;
    localparam logic [3:0] CBS_RST = 4'h0;
    localparam logic [3:0] EBS_RST = 4'h1;
    localparam logic [3:0] CBS_MAX = 4'hB;
    localparam logic [3:0] EBS_MAX = 4'hC;
    // Status register fields.
    localparam int HOLD_BIT = 0;
    localparam int XOFF_BIT = 1;
    localparam int COUNT_LSB = 8;
    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Port rate, pause timing and address aging.
    localparam int CLK_MHZ = 200;
    localparam int PORT_RATE_MBPS = 10000;
    localparam int BITS_PER_CYCLE = PORT_RATE_MBPS / CLK_MHZ;
    localparam int QUANTUM_BITS = 512;
    localparam logic [15:0] XOFF_QUANTA = 16'hFFFF;
    localparam logic [15:0] XON_QUANTA = 16'h0000;
    localparam int TICK_PERIOD_S = 1;
    localparam int AGE_TICK_CYCLES = CLK_MHZ * 1000000 * TICK_PERIOD_S;
    localparam int AGE_SECONDS = 300;
    localparam int AGE_LIMIT = AGE_SECONDS / TICK_PERIOD_S;
    localparam int TABLE_DEPTH = 16;
    localparam int IDX_W = 4;
    // Card modes and interface roles.
    typedef enum logic [1:0] {layer2_switching_mode, ten_gig_mux_mode,
        twenty_gig_mux_mode, ten_gig_transponder_mode} card_mode_t;
    typedef enum logic {subscriber_facing_role, provider_facing_role} role_t;
    // Burst size code to bucket depth in millibits.
    function automatic logic [39:0] burst_millibits(input logic [3:0] sel);
        logic [3:0] sh;
        sh = (sel > 4'h9) ? sel + 4'h1 : sel;
        return (40'h1000 << sh) * 40'h1F40;
    endfunction
    localparam logic [39:0] BKT_RST = burst_millibits(CBS_RST);
endpackage

// File: logic/mac_age_table.sv
`timescale 1ns/1ps
module mac_age_table (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // One pulse per aging period.
    input wire logic tick,
    // Learn request.
    input wire logic learn_valid,
    input wire logic [47:0] learn_mac,
    input wire logic [11:0] learn_vid,
    // Forwarding lookup.
    input wire logic [47:0] lkp_mac,
    input wire logic [11:0] lkp_vid,
    output logic lkp_hit,
    // Occupancy.
    output logic [eth_port_pkg::IDX_W:0] entries
);
    localparam int N = eth_port_pkg::TABLE_DEPTH;
    logic [N-1:0] vld_q;
    logic [47:0] mac_q [N];
    logic [11:0] vid_q [N];
    logic [8:0] age_q [N];
    logic hit, free;
    logic [eth_port_pkg::IDX_W-1:0] hit_idx, free_idx;
    logic [eth_port_pkg::IDX_W:0] cnt;

    // Compares one entry against an address and VLAN pair.
    function automatic logic match(input int i, input logic [47:0] m, input logic [11:0] v);
        return vld_q[i] && mac_q[i] == m && vid_q[i] == v;
    endfunction

    // Finds a matching entry, the lowest free slot and the occupancy.
    always_comb begin
        hit = 1'b0;
        free = 1'b0;
        hit_idx = '0;
        free_idx = '0;
        cnt = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (match(i, learn_mac, learn_vid)) begin
                hit = 1'b1;
                hit_idx = eth_port_pkg::IDX_W'(i);
            end
            if (!vld_q[i]) begin
                free = 1'b1;
                free_idx = eth_port_pkg::IDX_W'(i);
            end
            cnt = cnt + (eth_port_pkg::IDX_W + 1)'(vld_q[i]);
        end
    end

    // Ages entries each tick, then refreshes or inserts the learned pair.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            vld_q <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (tick && vld_q[i]) begin
                    if (age_q[i] == 9'(eth_port_pkg::AGE_LIMIT - 1)) begin
                        vld_q[i] <= 1'b0;
                    end else begin
                        age_q[i] <= age_q[i] + 9'h1;
                    end
                end
            end
            if (learn_valid && hit) begin
                vld_q[hit_idx] <= 1'b1;
                age_q[hit_idx] <= 9'h0;
            end else if (learn_valid && free) begin
                vld_q[free_idx] <= 1'b1;
                mac_q[free_idx] <= learn_mac;
                vid_q[free_idx] <= learn_vid;
                age_q[free_idx] <= 9'h0;
            end
        end
    end

    // Registered lookup answer and occupancy.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lkp_hit <= 1'b0;
            entries <= '0;
        end else begin
            lkp_hit <= 1'b0;
            for (int i = 0; i < N; i++) begin
                if (match(i, lkp_mac, lkp_vid)) begin
                    lkp_hit <= 1'b1;
                end
            end
            entries <= cnt;
        end
    end

    // An entry at the last age step is gone after the next tick.
    aging_expire_a: assert property (@(posedge clk) disable iff (!rstn)
        tick && vld_q[0] && age_q[0] == 9'(eth_port_pkg::AGE_LIMIT - 1)
        && !(learn_valid && !free && !hit) |=> !vld_q[0] || age_q[0] == 9'h0)
        else $error("Aged entry was not removed.");
endmodule

// File: logic/eth_port_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - With flow control on, congestion sends PAUSE and received PAUSE holds the transmitter.
// - With flow control off, no PAUSE is sent and every received PAUSE is discarded.
// - PAUSE is sent from local settings alone, whatever the peer has enabled.
// - The committed rate is set in 0.1 percent steps up to 100 percent, only in policing modes.
// - The committed burst takes one of twelve sizes from 4k to 16MB, 4k after reset.
// - The excess burst holds credit spilled from the committed bucket, None or 4k to 16MB.
// - In layer-2 mode the port is subscriber-facing or provider-facing.
// - Egress QoS is a switch, off after reset, effective only in layer-2 mode.
// - With learning on in layer-2 mode, source address and VLAN pairs enter the table; off after reset.
// - Learned entries age out after a fixed 300 seconds.
// - On enhanced variants learning also needs the frame's service VLAN to allow it.
module eth_port_ctrl #(
    parameter bit ENHANCED = 1'b1,
    parameter int unsigned TICK_CYCLES = eth_port_pkg::AGE_TICK_CYCLES
) (
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // AXI4-Lite write channels.
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read channels.
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Ingress frame descriptor.
    input wire logic FRM_VALID,
    input wire logic [13:0] FRM_BYTES,
    input wire logic [47:0] FRM_SRC_MAC,
    input wire logic [11:0] FRM_VID,
    input wire logic FRM_SVLAN_LRN,
    output logic FRM_FWD,
    output logic FRM_DROP,
    // Flow control with the peer.
    input wire logic BUF_CONGESTED,
    input wire logic RX_PAUSE_VALID,
    input wire logic [15:0] RX_PAUSE_QUANTA,
    output logic RX_PAUSE_DISCARD,
    output logic TX_PAUSE_VALID,
    output logic [15:0] TX_PAUSE_QUANTA,
    output logic TX_HOLD,
    // Port settings and forwarding lookup.
    output logic ROLE_PROVIDER,
    output logic EGRESS_QOS_EN,
    input wire logic [47:0] LKP_MAC,
    input wire logic [11:0] LKP_VID,
    output logic LKP_HIT
);
    logic [6:0] ctrl_q;
    logic [9:0] cir_q;
    logic [3:0] cbs_q, ebs_q;
    logic aw_q, w_q, bvalid_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q, wr_word, police_word, drops_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic wr_fire, wr_ok;
    eth_port_pkg::card_mode_t mode;
    logic fc_en, locked, police_on, learn_req;
    logic [39:0] cbkt_q, ebkt_q, c_sum, c_fill, e_sum, e_fill, spill;
    logic [39:0] cbs_cap, ebs_cap, cost;
    logic [15:0] refill;
    logic fit_c, fit_e, fwd_q, drop_q;
    logic [25:0] hold_q;
    logic xoff_q, tx_valid_q, rx_drop_q;
    logic [15:0] tx_quanta_q;
    logic [27:0] tick_cnt_q;
    logic tick;
    logic [eth_port_pkg::IDX_W:0] entries;

    // Applies AXI byte strobes to a register word.
    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
        input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Decoded settings.
    assign mode = eth_port_pkg::card_mode_t'(ctrl_q[eth_port_pkg::MODE_LSB +: 2]);
    assign fc_en = ctrl_q[eth_port_pkg::FC_BIT];
    assign locked = ctrl_q[eth_port_pkg::LOCK_BIT];
    assign police_on = mode != eth_port_pkg::ten_gig_transponder_mode;
    assign ROLE_PROVIDER = mode == eth_port_pkg::layer2_switching_mode
        && ctrl_q[eth_port_pkg::ROLE_BIT];
    assign EGRESS_QOS_EN = mode == eth_port_pkg::layer2_switching_mode
        && ctrl_q[eth_port_pkg::QOS_BIT];
    assign police_word = {8'h00, ebs_q, cbs_q, 6'h00, cir_q};

    // AXI handshakes: one write and one read in flight at a time.
    assign AWREADY = !aw_q && !bvalid_q;
    assign WREADY = !w_q && !bvalid_q;
    assign ARREADY = !rvalid_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign RVALID = rvalid_q;
    assign RDATA = rdata_q;
    assign RRESP = rresp_q;
    assign wr_fire = aw_q && w_q;

    // Checks a pending write against the lock and the legal field ranges.
    always_comb begin
        wr_word = 32'h0;
        wr_ok = 1'b0;
        if (awaddr_q == eth_port_pkg::CTRL_OFS) begin
            wr_word = strb_merge({25'h0, ctrl_q}, wdata_q, wstrb_q);
            wr_ok = locked || ((wr_word[6:0] ^ ctrl_q) & eth_port_pkg::PROT_MASK) == 7'h00;
        end else if (awaddr_q == eth_port_pkg::POLICE_OFS) begin
            wr_word = strb_merge(police_word, wdata_q, wstrb_q);
            wr_ok = locked
                && wr_word[eth_port_pkg::CIR_LSB +: 10] <= eth_port_pkg::CIR_FULL
                && wr_word[eth_port_pkg::CBS_LSB +: 4] <= eth_port_pkg::CBS_MAX
                && wr_word[eth_port_pkg::EBS_LSB +: 4] <= eth_port_pkg::EBS_MAX;
        end
    end

    // Write address and data capture, in either order, then the response.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= eth_port_pkg::RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_q <= 1'b1;
                awaddr_q <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_q <= 1'b1;
                wdata_q <= WDATA;
                wstrb_q <= WSTRB;
            end
            if (wr_fire) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? eth_port_pkg::RESP_OKAY : eth_port_pkg::RESP_SLVERR;
            end else if (bvalid_q && BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Settings registers; flow control, QoS and learning start off.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            ctrl_q <= eth_port_pkg::CTRL_RST;
            cir_q <= eth_port_pkg::CIR_FULL;
            cbs_q <= eth_port_pkg::CBS_RST;
            ebs_q <= eth_port_pkg::EBS_RST;
        end else if (wr_fire && wr_ok) begin
            if (awaddr_q == eth_port_pkg::CTRL_OFS) begin
                ctrl_q <= wr_word[6:0];
            end else begin
                cir_q <= wr_word[eth_port_pkg::CIR_LSB +: 10];
                cbs_q <= wr_word[eth_port_pkg::CBS_LSB +: 4];
                ebs_q <= wr_word[eth_port_pkg::EBS_LSB +: 4];
            end
        end
    end

    // Read data path; unmapped addresses answer SLVERR with zero data.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= eth_port_pkg::RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            rvalid_q <= 1'b1;
            rresp_q <= eth_port_pkg::RESP_OKAY;
            case (ARADDR)
                eth_port_pkg::CTRL_OFS: rdata_q <= {25'h0, ctrl_q};
                eth_port_pkg::POLICE_OFS: rdata_q <= police_word;
                eth_port_pkg::STATUS_OFS: rdata_q <= {19'h0, entries, 6'h00, xoff_q, TX_HOLD};
                eth_port_pkg::DROPS_OFS: rdata_q <= drops_q;
                default: begin
                    rdata_q <= 32'h0;
                    rresp_q <= eth_port_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // Bucket sizes, per-cycle refill and frame cost, all in millibits.
    assign cbs_cap = eth_port_pkg::burst_millibits(cbs_q);
    assign ebs_cap = (ebs_q == 4'h0) ? 40'h0 : eth_port_pkg::burst_millibits(ebs_q - 4'h1);
    assign refill = 16'(eth_port_pkg::BITS_PER_CYCLE) * {6'h00, cir_q};
    assign cost = 40'(FRM_BYTES) * 40'h1F40;

    // Refills the committed bucket; its overflow is credited to the excess bucket.
    always_comb begin
        c_sum = cbkt_q + 40'(refill);
        c_fill = (c_sum > cbs_cap) ? cbs_cap : c_sum;
        spill = (c_sum > cbs_cap) ? c_sum - cbs_cap : 40'h0;
        e_sum = ebkt_q + spill;
        e_fill = (e_sum > ebs_cap) ? ebs_cap : e_sum;
        fit_c = cost <= c_fill;
        fit_e = cost <= e_fill;
    end

    // Charges a conforming frame to the committed bucket first, then the excess one.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            cbkt_q <= eth_port_pkg::BKT_RST;
            ebkt_q <= eth_port_pkg::BKT_RST;
        end else if (FRM_VALID && police_on && fit_c) begin
            cbkt_q <= c_fill - cost;
            ebkt_q <= e_fill;
        end else if (FRM_VALID && police_on && fit_e) begin
            cbkt_q <= c_fill;
            ebkt_q <= e_fill - cost;
        end else begin
            cbkt_q <= c_fill;
            ebkt_q <= e_fill;
        end
    end

    // Frame verdict pulses and the drop counter.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            fwd_q <= 1'b0;
            drop_q <= 1'b0;
            drops_q <= 32'h0;
        end else begin
            fwd_q <= FRM_VALID && (!police_on || fit_c || fit_e);
            drop_q <= FRM_VALID && police_on && !fit_c && !fit_e;
            if (FRM_VALID && police_on && !fit_c && !fit_e) begin
                drops_q <= drops_q + 32'h1;
            end
        end
    end
    assign FRM_FWD = fwd_q;
    assign FRM_DROP = drop_q;

    // Received PAUSE loads the hold timer, which drains one port word per cycle.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN || !fc_en) begin
            hold_q <= 26'h0;
        end else if (RX_PAUSE_VALID) begin
            hold_q <= 26'(RX_PAUSE_QUANTA) * 26'(eth_port_pkg::QUANTUM_BITS);
        end else if (hold_q > 26'(eth_port_pkg::BITS_PER_CYCLE)) begin
            hold_q <= hold_q - 26'(eth_port_pkg::BITS_PER_CYCLE);
        end else begin
            hold_q <= 26'h0;
        end
    end
    assign TX_HOLD = hold_q != 26'h0;

    // Sends XOFF on congestion and XON when it clears, from local settings only.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            xoff_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_quanta_q <= eth_port_pkg::XON_QUANTA;
            rx_drop_q <= 1'b0;
        end else begin
            tx_valid_q <= 1'b0;
            rx_drop_q <= RX_PAUSE_VALID && !fc_en;
            if (fc_en && BUF_CONGESTED && !xoff_q) begin
                tx_valid_q <= 1'b1;
                tx_quanta_q <= eth_port_pkg::XOFF_QUANTA;
                xoff_q <= 1'b1;
            end else if (xoff_q && (!BUF_CONGESTED || !fc_en)) begin
                tx_valid_q <= fc_en;
                tx_quanta_q <= eth_port_pkg::XON_QUANTA;
                xoff_q <= 1'b0;
            end
        end
    end
    assign TX_PAUSE_VALID = tx_valid_q;
    assign TX_PAUSE_QUANTA = tx_quanta_q;
    assign RX_PAUSE_DISCARD = rx_drop_q;

    // Aging period divider.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN || tick) begin
            tick_cnt_q <= 28'h0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 28'h1;
        end
    end
    assign tick = tick_cnt_q == 28'(TICK_CYCLES - 1);

    // Learning needs the port switch, layer-2 mode and, when enhanced, the VLAN switch.
    assign learn_req = FRM_VALID && ctrl_q[eth_port_pkg::LRN_BIT]
        && mode == eth_port_pkg::layer2_switching_mode
        && (!ENHANCED || FRM_SVLAN_LRN);

    mac_age_table table_i (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .tick(tick),
        .learn_valid(learn_req),
        .learn_mac(FRM_SRC_MAC),
        .learn_vid(FRM_VID),
        .lkp_mac(LKP_MAC),
        .lkp_vid(LKP_VID),
        .lkp_hit(LKP_HIT),
        .entries(entries)
    );

    // Checks on flow control, policing, locking and learning.
    fc_reset_off_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        $rose(RSTN) |-> !fc_en && cir_q == 10'h3E8 && cbs_q == 4'h0 && ebs_q == 4'h1)
        else $error("Settings wrong after reset.");
    no_pause_off_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        TX_PAUSE_VALID |-> $past(fc_en))
        else $error("PAUSE sent with flow control off.");
    rx_discard_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        RX_PAUSE_VALID && !fc_en |=> RX_PAUSE_DISCARD && !TX_HOLD)
        else $error("Received PAUSE not discarded.");
    rx_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        RX_PAUSE_VALID && fc_en && RX_PAUSE_QUANTA == 16'h0001
        |=> TX_HOLD [*8] ##1 TX_HOLD [*3] ##1 !TX_HOLD)
        else $error("One quantum did not hold for 11 cycles.");
    xoff_send_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        fc_en && BUF_CONGESTED && !xoff_q |=> TX_PAUSE_VALID && TX_PAUSE_QUANTA == 16'hFFFF)
        else $error("Congestion did not send XOFF.");
    police_drop_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        FRM_VALID && police_on && cost > c_fill && cost > e_fill
        |=> FRM_DROP && !FRM_FWD && drops_q == $past(drops_q) + 32'h1)
        else $error("Nonconforming frame not dropped.");
    lock_reject_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        wr_fire && !locked && awaddr_q == 8'h04
        |=> $stable(cir_q) && $stable(cbs_q) && BVALID && BRESP == 2'h2)
        else $error("Unlocked policer write accepted.");
    qos_mode_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        EGRESS_QOS_EN || ROLE_PROVIDER |-> mode == eth_port_pkg::layer2_switching_mode)
        else $error("Layer-2 setting active outside layer-2 mode.");
    learn_off_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        !learn_req && !tick [*2] |=> entries == $past(entries))
        else $error("Table grew without learning.");
    cover_drop_c: cover property (@(posedge SYS_CLK) disable iff (!RSTN) FRM_DROP);
    cover_xon_c: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        TX_PAUSE_VALID && TX_PAUSE_QUANTA == 16'h0000);
    cover_hit_c: cover property (@(posedge SYS_CLK) disable iff (!RSTN) LKP_HIT);
endmodule

// File: verification/peer_port_model.sv
`timescale 1ns/1ps
module peer_port_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Request from the bench to send one PAUSE frame.
    input wire logic go,
    input wire logic [15:0] q,
    // PAUSE frames sent by the port under test.
    input wire logic tx_valid,
    // PAUSE frames towards the port under test, and a tally of those received.
    output logic rx_valid,
    output logic [15:0] rx_quanta,
    output int seen
);
    // Pauses are sent whatever the peer's own setting; the quanta wander between frames.
    always_ff @(posedge clk) begin
        rx_valid <= go;
        rx_quanta <= go ? q : ~rx_quanta;
        seen <= rstn ? seen + int'(tx_valid) : 0;
        if (!rstn) rx_quanta <= 16'hA5A5;
    end
endmodule

// File: verification/eth_port_policer_flowctl_tb.sv
`timescale 1ns/1ps
module eth_port_policer_flowctl_tb;
    // Design ports, peer controls and bench model state.
    logic SYS_CLK, RSTN, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
    logic RVALID, RREADY, FRM_VALID, FRM_SVLAN_LRN, FRM_FWD, FRM_DROP, BUF_CONGESTED, TX_HOLD;
    logic RX_PAUSE_VALID, RX_PAUSE_DISCARD, TX_PAUSE_VALID, ROLE_PROVIDER, EGRESS_QOS_EN, LKP_HIT;
    logic [7:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, d;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP, r;
    logic [13:0] FRM_BYTES;
    logic [47:0] FRM_SRC_MAC, LKP_MAC;
    logic [11:0] FRM_VID, LKP_VID;
    logic [15:0] RX_PAUSE_QUANTA, TX_PAUSE_QUANTA, q;
    logic go, dr;
    int seen, failures, checks, cb, eb, drops, b, seed = 32'h08E7;

    eth_port_ctrl #(.ENHANCED(1'h1), .TICK_CYCLES(2)) i_dut (.*);
    peer_port_model i_peer (.clk(SYS_CLK), .rstn(RSTN), .go(go), .q(q), .tx_valid(TX_PAUSE_VALID),
        .rx_valid(RX_PAUSE_VALID), .rx_quanta(RX_PAUSE_QUANTA), .seen(seen));

    // The clock toggles every half period of 2.5 ns.
    initial begin
        SYS_CLK = 1'h0;
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end

    // Compare one value and count it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Write one register over the bus and compare the response code.
    task automatic wc(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        bit k;
        k = 1'h0;
        r = 2'hX;
        AWADDR <= a;
        WDATA <= v;
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        repeat (60) if (!k) begin
            @(posedge SYS_CLK);
            if (AWREADY) AWVALID <= 1'h0;
            if (WREADY) WVALID <= 1'h0;
            if (BVALID) begin
                r = BRESP;
                BREADY <= 1'h0;
                k = 1'h1;
            end
        end
        @(posedge SYS_CLK);
        chk(r, e);
    endtask

    // Read one register over the bus into d and r.
    task automatic rd(input logic [7:0] a);
        bit k;
        k = 1'h0;
        r = 2'hX;
        d = 32'hX;
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        repeat (60) if (!k) begin
            @(posedge SYS_CLK);
            if (ARREADY) ARVALID <= 1'h0;
            if (RVALID) begin
                d = RDATA;
                r = RRESP;
                RREADY <= 1'h0;
                k = 1'h1;
            end
        end
        @(posedge SYS_CLK);
    endtask

    // Send one frame; the bench's two buckets decide whether it must pass.
    task automatic frame(input int n, input logic l);
        dr = 1'h0;
        if (n * 8000 <= cb) cb -= n * 8000;
        else if (n * 8000 <= eb) eb -= n * 8000;
        else dr = 1'h1;
        drops += int'(dr);
        FRM_BYTES <= 14'(n);
        FRM_SVLAN_LRN <= l;
        FRM_VALID <= 1'h1;
        @(posedge SYS_CLK);
        FRM_VALID <= 1'h0;
        @(posedge SYS_CLK);
        chk(FRM_DROP, dr);
        chk(FRM_FWD, !dr);
    endtask

    // Wait for the registered lookup and compare the hit flag.
    task automatic look(input logic e);
        repeat (2) @(posedge SYS_CLK);
        chk(LKP_HIT, e);
    endtask

    // Print the counts and the verdict, then stop.
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // A hang is cut short long after the sequence should have ended.
    initial begin
        #100000;
        failures++;
        report_and_stop();
    end

    // Main sequence: defaults, settings, learning and aging, policing, flow control.
    initial begin
        {RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, FRM_VALID, BUF_CONGESTED, go} = '0;
        {AWADDR, ARADDR, WDATA, FRM_BYTES, FRM_SVLAN_LRN, q} = '0;
        {FRM_SRC_MAC, LKP_MAC, FRM_VID, LKP_VID, WSTRB} = {48'h0200000000A1, 48'h0200000000A1,
            12'h00A, 12'h00A, 4'hF};
        cb = 32768000;
        eb = 32768000;
        repeat (5) @(posedge SYS_CLK);
        RSTN <= 1'h1;
        @(posedge SYS_CLK);
        rd(eth_port_pkg::CTRL_OFS);
        chk(d, 32'h10);
        rd(eth_port_pkg::POLICE_OFS);
        chk(d, 32'h001003E8);
        rd(8'h10);
        chk(r, eth_port_pkg::RESP_SLVERR);
        wc(eth_port_pkg::CTRL_OFS, 32'h16, eth_port_pkg::RESP_OKAY);
        chk({ROLE_PROVIDER, EGRESS_QOS_EN}, 2'h3);
        wc(eth_port_pkg::CTRL_OFS, 32'h36, eth_port_pkg::RESP_OKAY);
        chk({ROLE_PROVIDER, EGRESS_QOS_EN}, 2'h0);
        wc(eth_port_pkg::CTRL_OFS, 32'h18, eth_port_pkg::RESP_OKAY);
        frame(64, 1'h0);
        look(1'h0);
        frame(64, 1'h1);
        look(1'h1);
        rd(eth_port_pkg::STATUS_OFS);
        chk(d, 32'h00000100);
        repeat (560) @(posedge SYS_CLK);
        look(1'h1);
        repeat (80) @(posedge SYS_CLK);
        look(1'h0);
        wc(eth_port_pkg::POLICE_OFS, 32'h00100000, eth_port_pkg::RESP_OKAY);
        cb = 32768000;
        drops = 0;
        repeat (16) begin
            b = 64 + int'($unsigned($random(seed)) % 1437);
            frame(b, 1'h0);
        end
        rd(eth_port_pkg::DROPS_OFS);
        chk(d, drops);
        // The transponder mode does not police, so the bench bucket is made unlimited.
        wc(eth_port_pkg::CTRL_OFS, 32'h70, eth_port_pkg::RESP_OKAY);
        cb = 32'h7FFFFFFF;
        frame(1500, 1'h0);
        wc(eth_port_pkg::CTRL_OFS, 32'h01, eth_port_pkg::RESP_OKAY);
        wc(eth_port_pkg::POLICE_OFS, 32'h3E8, eth_port_pkg::RESP_SLVERR);
        wc(eth_port_pkg::CTRL_OFS, 32'h03, eth_port_pkg::RESP_SLVERR);
        BUF_CONGESTED <= 1'h1;
        repeat (2) @(posedge SYS_CLK);
        chk({TX_PAUSE_VALID, TX_PAUSE_QUANTA}, {1'h1, eth_port_pkg::XOFF_QUANTA});
        BUF_CONGESTED <= 1'h0;
        repeat (2) @(posedge SYS_CLK);
        chk({TX_PAUSE_VALID, TX_PAUSE_QUANTA}, {1'h1, eth_port_pkg::XON_QUANTA});
        go <= 1'h1;
        q <= 16'h0001;
        @(posedge SYS_CLK);
        go <= 1'h0;
        repeat (2) @(posedge SYS_CLK);
        chk(TX_HOLD, 1'h1);
        repeat (12) @(posedge SYS_CLK);
        chk(TX_HOLD, 1'h0);
        wc(eth_port_pkg::CTRL_OFS, 32'h00, eth_port_pkg::RESP_OKAY);
        BUF_CONGESTED <= 1'h1;
        go <= 1'h1;
        @(posedge SYS_CLK);
        go <= 1'h0;
        repeat (2) @(posedge SYS_CLK);
        chk({RX_PAUSE_DISCARD, TX_HOLD, TX_PAUSE_VALID}, 3'h4);
        chk(seen, 2);
        report_and_stop();
    end
endmodule
